// ### pcsarc_top.sv
// Clock selection, prescalers, start-up reset and power-on flag
//
// How it works
// - PLL multiplies the 12 MHz main clock by three, four or five.
// - Fast select stays set, ignoring zero writes, until PLL is powered up and stable.
// - Writing one to fast select returns the system clock to main.
// - Selected system source passes a divider of 1 through 16.
// - Aux clocks 1 and 2 come from main clock, independent of system.
// - 14-bit counter preset 3FFF, counts down, releases reset unless pin low.
// - Slow select zero picks prescaled main, one picks 32 kHz oscillator.
// - Fast select zero feeds divider from PLL, one from main; reset main.
// - Switch to PLL ignored while powered down or not yet stable.
// - Power-down bit keeps PLL off; clear lets it run or PMM decide.
// - Setting power-down is ignored while fast select is clear.
// - Aux clock 1 runs only when enabled and main clock is stable.
// - Aux clock 2 runs only when enabled and main clock is stable.
// - Power-on flag set at power-up, cleared only by writing zero.
// - Control byte: reserved, flag, aux enables, power-down, fast, slow.
// - Mode 011 triples, 100 quadruples, 101 quintuples; resets to 100.
// - System divisor field divides the source by field plus one.
module pcsarc_top #(
  parameter logic [13:0] START_PRESET = pcsarc_pkg::CNT_PRESET
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [23:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  // PLL and oscillators
  input wire logic i_pll_locked,
  input wire logic i_pll_tick,
  input wire logic i_slow_osc,
  output logic o_pll_stop,
  output logic [2:0] o_pll_mode,
  // Power management and external reset
  input wire logic i_pmm_pll_stop,
  input wire logic i_stop_main_osc,
  input wire logic i_ext_rst_n,
  // Clocks and reset out
  output logic o_sys_tick,
  output logic o_sys_src_pll,
  output logic o_slow_clk,
  output logic o_aux1_clk,
  output logic o_aux2_clk,
  output logic o_main_good,
  output logic o_chip_rst_n
);

  // One-hot register select, shared by the read and write paths
  function automatic logic [3:0] reg_decode(input logic [23:0] addr);
    logic [3:0] hit;
    hit = 4'h0;
    if (addr == pcsarc_pkg::ADDR_CTRL) begin
      hit = 4'h1;
    end else if (addr == pcsarc_pkg::ADDR_FAST) begin
      hit = 4'h2;
    end else if (addr == pcsarc_pkg::ADDR_SLOW) begin
      hit = 4'h4;
    end else if (addr == pcsarc_pkg::ADDR_AUX) begin
      hit = 4'h8;
    end
    return hit;
  endfunction

  // Control register fields
  logic por_flag;
  logic aux1_enable;
  logic aux2_enable;
  logic pll_power_down;
  logic fast_source_select;
  logic slow_source_select;
  logic next_por_flag;
  logic next_aux1_enable;
  logic next_aux2_enable;
  logic next_pll_power_down;
  logic next_fast_source_select;
  logic next_slow_source_select;

  // Prescaler registers
  logic [2:0] pll_mode;
  logic [3:0] system_clock_divisor;
  logic [7:0] slow_clock_prescaler;
  logic [7:0] auxiliary_clock_prescaler;
  logic [2:0] next_pll_mode;
  logic [3:0] next_system_clock_divisor;
  logic [7:0] next_slow_clock_prescaler;
  logic [7:0] next_auxiliary_clock_prescaler;
  logic [7:0] next_rd_data;

  // Synchronizer and source state
  logic lock_meta;
  logic pll_stable;
  pcsarc_pkg::pcsarc_src_e src;
  pcsarc_pkg::pcsarc_src_e next_src;

  // Clock outputs state
  logic next_pll_stop;
  logic next_slow_clk;
  logic next_aux1_clk;
  logic next_aux2_clk;
  logic next_chip_rst_n;
  logic slow_presc_clk;
  logic next_slow_presc_clk;

  // Divider links
  logic main_good;
  logic sys_tick_src;
  logic sys_pulse;
  logic sys_idle;
  logic slow_pulse;
  logic aux1_pulse;
  logic aux2_pulse;
  logic aux1_run;
  logic aux2_run;
  logic [3:0] hit_wr;
  logic [3:0] hit_rd;

  assign hit_wr = reg_decode(i_addr);
  assign hit_rd = hit_wr;

  // Register writes
  always_comb begin
    next_por_flag = por_flag;
    next_aux1_enable = aux1_enable;
    next_aux2_enable = aux2_enable;
    next_pll_power_down = pll_power_down;
    next_fast_source_select = fast_source_select;
    next_slow_source_select = slow_source_select;
    next_pll_mode = pll_mode;
    next_system_clock_divisor = system_clock_divisor;
    next_slow_clock_prescaler = slow_clock_prescaler;
    next_auxiliary_clock_prescaler = auxiliary_clock_prescaler;
    if (i_wr_en && hit_wr[0]) begin
      // Only a zero clears the flag; ones leave it alone
      if (!i_wr_data[pcsarc_pkg::BIT_POR]) begin
        next_por_flag = 1'b0;
      end
      next_aux1_enable = i_wr_data[pcsarc_pkg::BIT_AUX1];
      next_aux2_enable = i_wr_data[pcsarc_pkg::BIT_AUX2];
      if (i_wr_data[pcsarc_pkg::BIT_PWD]) begin
        // PLL must not stop under a running system clock
        if (fast_source_select) begin
          next_pll_power_down = 1'b1;
        end
      end else begin
        next_pll_power_down = 1'b0;
      end
      if (i_wr_data[pcsarc_pkg::BIT_FAST]) begin
        next_fast_source_select = 1'b1;
      end else if (!pll_power_down && pll_stable) begin
        next_fast_source_select = 1'b0;
      end
      next_slow_source_select = i_wr_data[pcsarc_pkg::BIT_SLOW];
    end
    if (i_wr_en && hit_wr[1]) begin
      // No guard against writes while on the PLL: software keeps off
      next_pll_mode = i_wr_data[pcsarc_pkg::MODE_MSB:pcsarc_pkg::MODE_LSB];
      next_system_clock_divisor =
        i_wr_data[pcsarc_pkg::DIV_MSB:pcsarc_pkg::DIV_LSB];
    end
    if (i_wr_en && hit_wr[2]) begin
      next_slow_clock_prescaler = i_wr_data;
    end
    if (i_wr_en && hit_wr[3]) begin
      next_auxiliary_clock_prescaler = i_wr_data;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      por_flag <= pcsarc_pkg::RST_CTRL[pcsarc_pkg::BIT_POR];
      aux1_enable <= pcsarc_pkg::RST_CTRL[pcsarc_pkg::BIT_AUX1];
      aux2_enable <= pcsarc_pkg::RST_CTRL[pcsarc_pkg::BIT_AUX2];
      pll_power_down <= pcsarc_pkg::RST_CTRL[pcsarc_pkg::BIT_PWD];
      fast_source_select <= pcsarc_pkg::RST_CTRL[pcsarc_pkg::BIT_FAST];
      slow_source_select <= pcsarc_pkg::RST_CTRL[pcsarc_pkg::BIT_SLOW];
      pll_mode <=
        pcsarc_pkg::RST_FAST[pcsarc_pkg::MODE_MSB:pcsarc_pkg::MODE_LSB];
      system_clock_divisor <=
        pcsarc_pkg::RST_FAST[pcsarc_pkg::DIV_MSB:pcsarc_pkg::DIV_LSB];
      slow_clock_prescaler <= pcsarc_pkg::RST_SLOW;
      auxiliary_clock_prescaler <= pcsarc_pkg::RST_AUX;
    end else begin
      por_flag <= next_por_flag;
      aux1_enable <= next_aux1_enable;
      aux2_enable <= next_aux2_enable;
      pll_power_down <= next_pll_power_down;
      fast_source_select <= next_fast_source_select;
      slow_source_select <= next_slow_source_select;
      pll_mode <= next_pll_mode;
      system_clock_divisor <= next_system_clock_divisor;
      slow_clock_prescaler <= next_slow_clock_prescaler;
      auxiliary_clock_prescaler <= next_auxiliary_clock_prescaler;
    end
  end

  // Register reads, data valid one cycle after the strobe
  always_comb begin
    next_rd_data = 8'h00;
    if (i_rd_en) begin
      if (hit_rd[0]) begin
        next_rd_data = {2'h0, por_flag, aux2_enable, aux1_enable,
          pll_power_down, fast_source_select, slow_source_select};
      end else if (hit_rd[1]) begin
        next_rd_data = {1'b0, pll_mode, system_clock_divisor};
      end else if (hit_rd[2]) begin
        next_rd_data = slow_clock_prescaler;
      end else if (hit_rd[3]) begin
        next_rd_data = auxiliary_clock_prescaler;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= next_rd_data;
    end
  end

  // Lock indication comes from the analog PLL, so two flops first
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      lock_meta <= 1'b0;
      pll_stable <= 1'b0;
    end else begin
      lock_meta <= i_pll_locked;
      pll_stable <= lock_meta;
    end
  end

  // Source state: change only on a divider boundary
  always_comb begin
    next_src = src;
    case (src)
      pcsarc_pkg::SRC_MAIN: begin
        if (!fast_source_select && sys_idle) begin
          next_src = pcsarc_pkg::SRC_PLL;
        end
      end
      pcsarc_pkg::SRC_PLL: begin
        if (fast_source_select && sys_idle) begin
          next_src = pcsarc_pkg::SRC_MAIN;
        end
      end
      default: begin
        next_src = pcsarc_pkg::SRC_MAIN;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      src <= pcsarc_pkg::SRC_MAIN;
    end else begin
      src <= next_src;
    end
  end

  // Main clock ticks every cycle; PLL ticks arrive as a pulse stream
  assign sys_tick_src = (src == pcsarc_pkg::SRC_PLL) ? i_pll_tick : 1'b1;

  pcsarc_div #(
    .W(4)
  ) u_sys_div (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_run(main_good),
    .i_tick(sys_tick_src),
    .i_div(system_clock_divisor),
    .o_pulse(sys_pulse),
    .o_idle(sys_idle)
  );

  pcsarc_div #(
    .W(8)
  ) u_slow_div (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_run(main_good),
    .i_tick(1'b1),
    .i_div(slow_clock_prescaler),
    .o_pulse(slow_pulse),
    .o_idle()
  );

  assign aux1_run = aux1_enable && main_good;
  assign aux2_run = aux2_enable && main_good;

  // Aux dividers see only the main clock, never the system divider
  pcsarc_div #(
    .W(4)
  ) u_aux1_div (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_run(aux1_run),
    .i_tick(1'b1),
    .i_div(auxiliary_clock_prescaler[pcsarc_pkg::AUX1_MSB:
      pcsarc_pkg::AUX1_LSB]),
    .o_pulse(aux1_pulse),
    .o_idle()
  );

  pcsarc_div #(
    .W(4)
  ) u_aux2_div (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_run(aux2_run),
    .i_tick(1'b1),
    .i_div(auxiliary_clock_prescaler[pcsarc_pkg::AUX2_MSB:
      pcsarc_pkg::AUX2_LSB]),
    .o_pulse(aux2_pulse),
    .o_idle()
  );

  // Oscillator stop restarts the countdown as well as reset does
  pcsarc_start #(
    .PRESET(START_PRESET)
  ) u_start (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_preset(i_stop_main_osc),
    .o_good(main_good)
  );

  // Clock outputs
  always_comb begin
    // PMM may stop the PLL only while the system runs from main
    next_pll_stop = pll_power_down ||
      (i_pmm_pll_stop && fast_source_select &&
      src == pcsarc_pkg::SRC_MAIN);
    next_slow_presc_clk = slow_presc_clk;
    if (!main_good) begin
      next_slow_presc_clk = 1'b0;
    end else if (slow_pulse) begin
      next_slow_presc_clk = !slow_presc_clk;
    end
    next_slow_clk = slow_source_select ? i_slow_osc
      : slow_presc_clk;
    // Stopped aux clocks park low
    next_aux1_clk = o_aux1_clk;
    if (!aux1_run) begin
      next_aux1_clk = 1'b0;
    end else if (aux1_pulse) begin
      next_aux1_clk = !o_aux1_clk;
    end
    next_aux2_clk = o_aux2_clk;
    if (!aux2_run) begin
      next_aux2_clk = 1'b0;
    end else if (aux2_pulse) begin
      next_aux2_clk = !o_aux2_clk;
    end
    next_chip_rst_n = main_good && i_ext_rst_n;
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_pll_stop <= 1'b1;
      o_pll_mode <= pcsarc_pkg::MODE_X4;
      o_sys_tick <= 1'b0;
      o_sys_src_pll <= 1'b0;
      slow_presc_clk <= 1'b0;
      o_slow_clk <= 1'b0;
      o_aux1_clk <= 1'b0;
      o_aux2_clk <= 1'b0;
      o_main_good <= 1'b0;
      o_chip_rst_n <= 1'b0;
    end else begin
      o_pll_stop <= next_pll_stop;
      o_pll_mode <= pll_mode;
      o_sys_tick <= sys_pulse;
      o_sys_src_pll <= (next_src == pcsarc_pkg::SRC_PLL);
      slow_presc_clk <= next_slow_presc_clk;
      o_slow_clk <= next_slow_clk;
      o_aux1_clk <= next_aux1_clk;
      o_aux2_clk <= next_aux2_clk;
      o_main_good <= main_good;
      o_chip_rst_n <= next_chip_rst_n;
    end
  end

endmodule // pcsarc_top

// ### pcsarc_pkg.sv
// Constants and types for the clock select and reset control block
package pcsarc_pkg;

  // Register addresses
  localparam logic [23:0] ADDR_CTRL = 24'hFFFC40;
  localparam logic [23:0] ADDR_FAST = 24'hFFFC42;
  localparam logic [23:0] ADDR_SLOW = 24'hFFFC44;
  localparam logic [23:0] ADDR_AUX = 24'hFFFC46;

  // Control register bit positions
  localparam int BIT_POR = 5;
  localparam int BIT_AUX2 = 4;
  localparam int BIT_AUX1 = 3;
  localparam int BIT_PWD = 2;
  localparam int BIT_FAST = 1;
  localparam int BIT_SLOW = 0;

  // Fast prescaler field layout
  localparam int MODE_LSB = 4;
  localparam int MODE_MSB = 6;
  localparam int DIV_LSB = 0;
  localparam int DIV_MSB = 3;

  // Aux prescaler field layout
  localparam int AUX1_LSB = 0;
  localparam int AUX1_MSB = 3;
  localparam int AUX2_LSB = 4;
  localparam int AUX2_MSB = 7;

  // Reset values
  localparam logic [7:0] RST_CTRL = 8'h26;
  localparam logic [7:0] RST_FAST = 8'h4F;
  localparam logic [7:0] RST_SLOW = 8'hB6;
  localparam logic [7:0] RST_AUX = 8'hFF;

  // PLL multiplication codes
  localparam logic [2:0] MODE_X3 = 3'h3;
  localparam logic [2:0] MODE_X4 = 3'h4;
  localparam logic [2:0] MODE_X5 = 3'h5;

  // Start-up countdown
  localparam int CNT_W = 14;
  localparam logic [13:0] CNT_PRESET = 14'h3FFF;

  // Source that feeds the system divider
  typedef enum logic {SRC_MAIN, SRC_PLL} pcsarc_src_e;

endpackage

// ### pcsarc_div.sv
// Programmable tick divider: pulses once every div+1 input ticks
module pcsarc_div #(
  parameter int W = 4
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_run,
  input wire logic i_tick,
  input wire logic [W-1:0] i_div,
  // Result
  output logic o_pulse,
  output logic o_idle
);

  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic next_pulse;

  always_comb begin
    next_count = count;
    next_pulse = 1'b0;
    if (!i_run) begin
      next_count = '0;
    end else if (i_tick) begin
      if (count >= i_div) begin
        next_count = '0;
        next_pulse = 1'b1;
      end else begin
        next_count = W'(count + 1'b1);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      count <= '0;
      o_pulse <= 1'b0;
    end else begin
      count <= next_count;
      o_pulse <= next_pulse;
    end
  end

  // Idle means a period boundary: safe point to change the source
  assign o_idle = (count == '0);

endmodule // pcsarc_div

// ### pcsarc_start.sv
// Start-up countdown that marks the main clock as good at zero
module pcsarc_start #(
  parameter logic [13:0] PRESET = pcsarc_pkg::CNT_PRESET
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_preset,
  // Result
  output logic o_good
);

  logic [pcsarc_pkg::CNT_W-1:0] count;
  logic [pcsarc_pkg::CNT_W-1:0] next_count;
  logic next_good;

  always_comb begin
    next_count = count;
    if (i_preset) begin
      next_count = PRESET;
    end else if (count != '0) begin
      next_count = pcsarc_pkg::CNT_W'(count - 1'b1);
    end
    next_good = (next_count == '0);
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      count <= PRESET;
      o_good <= 1'b0;
    end else begin
      count <= next_count;
      o_good <= next_good;
    end
  end

endmodule // pcsarc_start

// ### pcsarc_monitor.sv
// Assertion checker for the clock select and reset control block
module pcsarc_monitor #(
  parameter logic [13:0] START_PRESET = pcsarc_pkg::CNT_PRESET
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Register port
  input wire logic [23:0] i_addr,
  input wire logic i_rd_en,
  input wire logic [7:0] o_rd_data,
  // Power management and pins
  input wire logic i_stop_main_osc,
  input wire logic i_ext_rst_n,
  // Design outputs
  input wire logic o_pll_stop,
  input wire logic [2:0] o_pll_mode,
  input wire logic o_sys_src_pll,
  input wire logic o_aux1_clk,
  input wire logic o_aux2_clk,
  input wire logic o_main_good,
  input wire logic o_chip_rst_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  // Cycles since countdown start; saturates so it never wraps
  logic [15:0] gcnt;
  logic [15:0] next_gcnt;
  always_comb begin
    next_gcnt = gcnt;
    if (i_rst || i_stop_main_osc) begin
      next_gcnt = 16'h0000;
    end else if (gcnt != 16'hFFFF) begin
      next_gcnt = gcnt + 16'h0001;
    end
  end
  always_ff @(posedge i_ref_clk) begin
    gcnt <= next_gcnt;
  end

  a_rd_idle_zero: assert property (
    !$past(i_rd_en) |-> o_rd_data == 8'h00)
    else $error("read data not zero outside read cycle");
  a_rd_reserved_zero: assert property (
    $past(i_rd_en) && $past(i_addr) == pcsarc_pkg::ADDR_CTRL
    |-> o_rd_data[7:6] == 2'h0)
    else $error("reserved control bits read nonzero");
  a_stop_after_rst: assert property (
    $past(i_rst) |-> o_pll_stop)
    else $error("PLL not stopped after reset");
  a_mode_after_rst: assert property (
    $past(i_rst) |-> o_pll_mode == 3'h4)
    else $error("PLL mode not 4 after reset");
  a_src_after_rst: assert property (
    $past(i_rst) |-> !o_sys_src_pll)
    else $error("system source not main after reset");
  a_pll_run_src: assert property (
    $rose(o_sys_src_pll) |-> !o_pll_stop)
    else $error("switched to PLL while it is stopped");
  a_aux_stop_bad: assert property (
    !o_main_good && !$past(o_main_good) && !$past(o_main_good, 2)
    |-> !o_aux1_clk && !o_aux2_clk)
    else $error("aux clock running without good main clock");
  a_good_delay: assert property (
    $rose(o_main_good) |-> gcnt >= {2'h0, START_PRESET}
    && gcnt <= {2'h0, START_PRESET} + 16'h0003)
    else $error("main good at wrong time");
  a_ext_rst_hold: assert property (
    !i_ext_rst_n |=> !o_chip_rst_n)
    else $error("chip reset released while pin low");
  // Both flops load from the same countdown result, so chip reset rises with main good, or later while the pin is low
  a_chip_rst_good: assert property (
    $rose(o_chip_rst_n) |-> o_main_good)
    else $error("chip reset released before main good");
endmodule // pcsarc_monitor

bind pcsarc_top pcsarc_monitor #(.START_PRESET(START_PRESET))
  i_pcsarc_monitor (
  .i_ref_clk, .i_rst, .i_addr, .i_rd_en, .o_rd_data, .i_stop_main_osc,
  .i_ext_rst_n, .o_pll_stop, .o_pll_mode, .o_sys_src_pll, .o_aux1_clk,
  .o_aux2_clk, .o_main_good, .o_chip_rst_n);

// ### pcsarc_pll_model.sv
// Behavioural PLL: locks a while after power-up, ticks every other cycle
module pcsarc_pll_model #(
  parameter int LOCK_CYC = 20
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // Control from the block
  input wire logic i_stop,
  input wire logic [2:0] i_mode,
  // PLL outputs
  output logic o_locked,
  output logic o_tick
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt;
  logic ph;
  // Any stop drops lock at once, so the block must wait again
  always @(posedge i_ref_clk) begin
    if (i_rst || i_stop) begin
      cnt <= 0;
      o_locked <= 1'b0;
      o_tick <= 1'b0;
      ph <= 1'b0;
    end else begin
      if (cnt < LOCK_CYC) cnt <= cnt + 1;
      o_locked <= (cnt >= LOCK_CYC);
      ph <= ~ph;
      // Tick rate stands in for the multiplied clock of any mode but 000, which gives no ticks
      o_tick <= (cnt >= LOCK_CYC) && ph && (i_mode != 3'h0);
    end
  end
endmodule // pcsarc_pll_model

// ### pcsarc_top_bench.sv
// Self-checking bench for the clock select and reset control block
module pcsarc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_wr_en = 1'b0, i_rd_en = 1'b0;
  logic [23:0] i_addr = 24'h000000;
  logic [7:0] i_wr_data = 8'h00, o_rd_data, d;
  logic i_pll_locked, i_pll_tick, i_slow_osc = 1'b0, o_pll_stop;
  logic i_pmm_pll_stop = 1'b0, i_stop_main_osc = 1'b0, i_ext_rst_n = 1'b1;
  logic [2:0] o_pll_mode;
  logic o_sys_tick, o_sys_src_pll, o_slow_clk, o_aux1_clk, o_aux2_clk;
  logic o_main_good, o_chip_rst_n;
  int failures = 0, n_checks = 0, n;
  localparam logic [13:0] PRE = 14'h0010;

  always #5 i_ref_clk = ~i_ref_clk;

  pcsarc_top #(.START_PRESET(PRE)) i_pcsarc_top (.*);
  pcsarc_pll_model i_pcsarc_pll_model (.i_ref_clk, .i_rst,
    .i_stop(o_pll_stop), .i_mode(o_pll_mode), .o_locked(i_pll_locked),
    .o_tick(i_pll_tick));

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    n_checks++;
    if (got != exp) begin
      failures++;
      $display("ERROR %0t count %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [7:0] v);
    @(posedge i_ref_clk);
    i_wr_en <= 1'b1; i_addr <= a; i_wr_data <= v;
    @(posedge i_ref_clk);
    i_wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [23:0] a, output logic [7:0] v);
    @(posedge i_ref_clk);
    i_rd_en <= 1'b1; i_addr <= a;
    @(posedge i_ref_clk);
    i_rd_en <= 1'b0;
    #1 v = o_rd_data;
  endtask
  // Samples cyc+1 times; pulses for sel 0, rising edges otherwise
  task automatic count(input int sel, input int cyc, output int c);
    logic p, v;
    c = 0;
    for (int k = 0; k <= cyc; k++) begin
      @(posedge i_ref_clk);
      #1;
      case (sel)
        0: v = o_sys_tick;
        1: v = o_aux1_clk;
        2: v = o_aux2_clk;
        default: v = o_slow_clk;
      endcase
      if (k > 0 && v === 1'b1 && (sel == 0 || p === 1'b0)) c++;
      p = v;
    end
  endtask
  task automatic await(input int sel, input int lim);
    logic v;
    v = 1'b0;
    for (int k = 0; k < lim && v !== 1'b1; k++) begin
      @(posedge i_ref_clk);
      #1;
      case (sel)
        0: v = o_chip_rst_n;
        1: v = o_sys_src_pll;
        2: v = ~o_sys_src_pll;
        default: v = o_main_good;
      endcase
    end
    chk8({7'h00, v}, 8'h01);
  endtask

  task automatic t_reset_regs;
    rd(pcsarc_pkg::ADDR_CTRL, d); chk8(d, 8'h26);
    rd(pcsarc_pkg::ADDR_FAST, d); chk8(d, 8'h4F);
    rd(pcsarc_pkg::ADDR_SLOW, d); chk8(d, 8'hB6);
    rd(pcsarc_pkg::ADDR_AUX, d); chk8(d, 8'hFF);
    wr(24'hFFFC48, 8'hFF);
    rd(24'hFFFC48, d); chk8(d, 8'h00);
    // Fast select clear refused while powered down, reserved bits drop
    wr(pcsarc_pkg::ADDR_CTRL, 8'hE4);
    rd(pcsarc_pkg::ADDR_CTRL, d); chk8(d, 8'h26);
    $display("test reset_regs done");
  endtask

  task automatic t_pll_switch;
    logic [2:0] m [3] = '{pcsarc_pkg::MODE_X4, pcsarc_pkg::MODE_X5,
      pcsarc_pkg::MODE_X3};
    foreach (m[k]) begin
      wr(pcsarc_pkg::ADDR_FAST, {1'b0, m[k], 4'h0});
      // Mode output is one flop behind the register
      @(posedge i_ref_clk);
      #1;
      chk8({5'h00, o_pll_mode}, {5'h00, m[k]});
    end
    wr(pcsarc_pkg::ADDR_CTRL, 8'h22);
    repeat (2) @(posedge i_ref_clk);
    chk8({7'h00, o_pll_stop}, 8'h00);
    i_pmm_pll_stop <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    chk8({7'h00, o_pll_stop}, 8'h01);
    i_pmm_pll_stop <= 1'b0;
    wr(pcsarc_pkg::ADDR_CTRL, 8'h20);
    rd(pcsarc_pkg::ADDR_CTRL, d); chk8({7'h00, d[1]}, 8'h01);
    for (int k = 0; k < 20 && d[1] !== 1'b0; k++) begin
      repeat (4) @(posedge i_ref_clk);
      wr(pcsarc_pkg::ADDR_CTRL, 8'h20);
      rd(pcsarc_pkg::ADDR_CTRL, d);
    end
    chk8({7'h00, d[1]}, 8'h00);
    await(1, 40);
    wr(pcsarc_pkg::ADDR_CTRL, 8'h24);
    rd(pcsarc_pkg::ADDR_CTRL, d); chk8(d, 8'h20);
    repeat (4) @(posedge i_ref_clk);
    count(0, 20, n); chkn(n, 10);
    wr(pcsarc_pkg::ADDR_CTRL, 8'h22);
    await(2, 40);
    wr(pcsarc_pkg::ADDR_FAST, 8'h33);
    repeat (8) @(posedge i_ref_clk);
    count(0, 40, n); chkn(n, 10);
    $display("test pll_switch done");
  endtask

  task automatic t_aux_slow;
    wr(pcsarc_pkg::ADDR_AUX, 8'h10);
    wr(pcsarc_pkg::ADDR_SLOW, 8'h01);
    wr(pcsarc_pkg::ADDR_CTRL, 8'h3A);
    repeat (8) @(posedge i_ref_clk);
    count(1, 40, n); chkn(n, 20);
    count(2, 40, n); chkn(n, 10);
    count(3, 40, n); chkn(n, 10);
    wr(pcsarc_pkg::ADDR_CTRL, 8'h23);
    i_slow_osc <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    chk8({6'h00, o_slow_clk, o_aux1_clk}, 8'h02);
    i_slow_osc <= 1'b0;
    repeat (6) @(posedge i_ref_clk);
    chk8({6'h00, o_slow_clk, o_aux2_clk}, 8'h00);
    $display("test aux_slow done");
  endtask

  task automatic t_por_reset;
    wr(pcsarc_pkg::ADDR_CTRL, 8'h1A);
    rd(pcsarc_pkg::ADDR_CTRL, d); chk8(d, 8'h1A);
    wr(pcsarc_pkg::ADDR_CTRL, 8'h3A);
    rd(pcsarc_pkg::ADDR_CTRL, d); chk8(d, 8'h1A);
    // Stopped main clock must drop main good and park aux clock 1 low
    @(posedge i_ref_clk);
    i_stop_main_osc <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    chk8({6'h00, o_main_good, o_aux1_clk}, 8'h00);
    i_stop_main_osc <= 1'b0;
    await(3, 40);
    @(posedge i_ref_clk);
    i_ext_rst_n <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    chk8({7'h00, o_chip_rst_n}, 8'h00);
    i_ext_rst_n <= 1'b1;
    await(0, 10);
    $display("test por_reset done");
  endtask

  task automatic conclude;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #200000;
    failures++;
    $display("ERROR %0t watchdog expired", $time);
    conclude();
  end

  initial begin
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    await(0, 100);
    t_reset_regs();
    t_pll_switch();
    t_aux_slow();
    t_por_reset();
    conclude();
  end
endmodule // pcsarc_top_bench
